//--- core/vco_output_config_regs.sv
// Write-only VCO output configuration register bank behind the indirect write port
`timescale 1ns/10ps
`include "vco_output_config_regs.svh"
module vco_output_config_regs
    import vco_output_config_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Indirect write port, one-cycle strobe
    input wire logic wr_stb,
    input wire logic [2:0] wr_subsys_id,
    input wire logic [3:0] wr_addr,
    input wire logic [8:0] wr_data,
    // Status from the rest of the subsystem, same clock
    input wire logic vco_cal_busy,
    input wire logic lock_detect,
    input wire logic [5:0] out_divide_ratio,
    // Decoded controls
    output logic best_noise_mode,
    output logic positive_output_leg,
    output logic negative_output_leg,
    output logic internal_term_en,
    output logic high_out_res,
    output logic output_mute,
    output logic [8:0] cal_bias_trim,
    output logic [8:0] coarse_cal_trim,
    output logic [8:0] upper_cal_trim
);
    logic [8:0] cfg_ff;
    logic [8:0] bias_ff;
    logic [8:0] coarse_ff;
    logic [8:0] upper_ff;
    logic output_mute_ff;
    logic nxt_output_mute;
    logic sel_ok;
    mute_mode_t mute_mode;

    // Address hit for this subsystem; used by all four registers
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    assign sel_ok = wr_stb && (wr_subsys_id == `VCO_SUBSYS_ID);

    // Config register; whole word replaced
    // reset value holds priority 01
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_ff <= `RST_VCO_OUTPUT_CONFIG;
        end else if (sel_ok && hit(wr_addr, `ADDR_VCO_OUTPUT_CONFIG)) begin
            cfg_ff <= wr_data;
        end
    end

    // Trim registers, stored as written since host owns their values
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bias_ff <= `RST_VCO_CAL_BIAS_TRIM;
            coarse_ff <= `RST_VCO_COARSE_CAL_TRIM;
            upper_ff <= `RST_VCO_UPPER_CAL_TRIM;
        end else if (sel_ok) begin
            if (hit(wr_addr, `ADDR_VCO_CAL_BIAS_TRIM)) begin
                bias_ff <= wr_data;
            end else if (hit(wr_addr, `ADDR_VCO_COARSE_CAL_TRIM)) begin
                coarse_ff <= wr_data;
            end else if (hit(wr_addr, `ADDR_VCO_UPPER_CAL_TRIM)) begin
                upper_ff <= wr_data;
            end
        end
    end

    // only code 11 means best noise; unsupported codes fall back to low current
    assign best_noise_mode = (cfg_ff[`FLD_PRIO_LSB +: 2] == prio_best_noise);
    assign positive_output_leg = cfg_ff[`FLD_POS_LEG];
    assign negative_output_leg = cfg_ff[`FLD_NEG_LEG];
    assign internal_term_en = cfg_ff[`FLD_INT_TERM];
    assign high_out_res = cfg_ff[`FLD_HIGH_RES];
    assign cal_bias_trim = bias_ff;
    assign coarse_cal_trim = coarse_ff;
    assign upper_cal_trim = upper_ff;
    assign mute_mode = mute_mode_t'(cfg_ff[`FLD_MUTE_LSB +: 2]);

    always_comb begin
        nxt_output_mute = 1'b0;
        case (mute_mode)
            mute_on_div_zero: nxt_output_mute = (out_divide_ratio == 6'h00);
            mute_on_cal: nxt_output_mute = vco_cal_busy;
            mute_on_cal_or_unlock: nxt_output_mute = vco_cal_busy || !lock_detect;
            default: nxt_output_mute = 1'b1;
        endcase
    end

    // Registered so the mute line never glitches on status changes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_mute_ff <= 1'b0;
        end else begin
            output_mute_ff <= nxt_output_mute;
        end
    end
    assign output_mute = output_mute_ff;

    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_OUTPUT_CONFIG |=> cfg_ff == $past(wr_data))
        else $error("config write not stored");

    AST_FOREIGN_IGNORED: assert property (@(posedge clk) disable iff (!rst_b)
        wr_stb && wr_subsys_id != `VCO_SUBSYS_ID |=> $stable(cfg_ff) && $stable(bias_ff))
        else $error("foreign subsystem write took effect");

    AST_RESET_PRIO: assert property (@(posedge clk)
        !rst_b |=> !best_noise_mode && !positive_output_leg && !negative_output_leg && internal_term_en && !high_out_res)
        else $error("reset defaults wrong");

    AST_PRIO_SEL: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_OUTPUT_CONFIG |=> best_noise_mode == ($past(wr_data[1:0]) == 2'h3))
        else $error("priority decode wrong");

    AST_POS_LEG: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_OUTPUT_CONFIG |=> positive_output_leg == $past(wr_data[2]))
        else $error("positive leg enable wrong");

    AST_NEG_LEG: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_OUTPUT_CONFIG |=> negative_output_leg == $past(wr_data[3]))
        else $error("negative leg enable wrong");

    AST_TERM: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_OUTPUT_CONFIG |=> internal_term_en == $past(wr_data[4]))
        else $error("termination select wrong");

    AST_RES: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_OUTPUT_CONFIG |=> high_out_res == $past(wr_data[5]))
        else $error("resistance select wrong");

    sequence mute_always_set;
        cfg_ff[8:7] == 2'h3 ##1 cfg_ff[8:7] == 2'h3;
    endsequence
    AST_MUTE_ALWAYS: assert property (@(posedge clk) disable iff (!rst_b)
        mute_always_set |-> output_mute)
        else $error("mute always not muted");

    // calibration mode mutes during calibration one cycle later
    AST_MUTE_CAL: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_ff[8:7] == 2'h1 && vco_cal_busy |=> output_mute)
        else $error("calibration mute missing");

    AST_MUTE_CAL_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_ff[8:7] == 2'h1 && !vco_cal_busy |=> !output_mute)
        else $error("calibration mode muted while idle");

    AST_MUTE_DIV_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_ff[8:7] == 2'h0 |=> output_mute == $past(out_divide_ratio == 6'h00))
        else $error("divide zero mute wrong");

    AST_MUTE_CAL_UNLOCK: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_ff[8:7] == 2'h2 |=> output_mute == $past(vco_cal_busy || !lock_detect))
        else $error("calibration or unlock mute wrong");

    // mute always, two steps after write; status never matters here
    sequence cfg_mute_always_written;
        sel_ok && wr_addr == `ADDR_VCO_OUTPUT_CONFIG && wr_data[8:7] == 2'h3;
    endsequence
    AST_MUTE_AFTER_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_mute_always_written |=> ##1 output_mute)
        else $error("mute always write did not silence output");

    AST_MUTE_RESET: assert property (@(posedge clk)
        !rst_b |=> !output_mute)
        else $error("mute not cleared by reset");

    AST_BIAS_LANDS: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_CAL_BIAS_TRIM |=> bias_ff == $past(wr_data))
        else $error("bias write not stored");

    AST_COARSE_LANDS: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_COARSE_CAL_TRIM |=> coarse_ff == $past(wr_data))
        else $error("coarse write not stored");

    AST_UPPER_LANDS: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr == `ADDR_VCO_UPPER_CAL_TRIM |=> upper_ff == $past(wr_data))
        else $error("upper write not stored");

    AST_FOREIGN_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
        sel_ok && wr_addr != `ADDR_VCO_OUTPUT_CONFIG && wr_addr != `ADDR_VCO_CAL_BIAS_TRIM
        && wr_addr != `ADDR_VCO_COARSE_CAL_TRIM && wr_addr != `ADDR_VCO_UPPER_CAL_TRIM
        |=> $stable(cfg_ff) && $stable(bias_ff) && $stable(coarse_ff) && $stable(upper_ff))
        else $error("unused address write took effect");

    AST_TRIM_RESET: assert property (@(posedge clk)
        !rst_b |=> bias_ff == `RST_VCO_CAL_BIAS_TRIM && coarse_ff == `RST_VCO_COARSE_CAL_TRIM
        && upper_ff == `RST_VCO_UPPER_CAL_TRIM)
        else $error("trim reset values wrong");
endmodule

//--- pkg/vco_output_config_regs.svh
// Offsets, field positions and reset values of the VCO output configuration bank
`ifndef VCO_OUTPUT_CONFIG_REGS_SVH
`define VCO_OUTPUT_CONFIG_REGS_SVH
`define ADDR_VCO_OUTPUT_CONFIG 4'h3
`define ADDR_VCO_CAL_BIAS_TRIM 4'h4
`define ADDR_VCO_COARSE_CAL_TRIM 4'h5
`define ADDR_VCO_UPPER_CAL_TRIM 4'h6
`define VCO_SUBSYS_ID 3'h0
`define FLD_PRIO_LSB 0
`define FLD_POS_LEG 2
`define FLD_NEG_LEG 3
`define FLD_INT_TERM 4
`define FLD_HIGH_RES 5
`define FLD_MUTE_LSB 7
`define RST_VCO_OUTPUT_CONFIG 9'h091
`define RST_VCO_CAL_BIAS_TRIM 9'h0c9
`define RST_VCO_COARSE_CAL_TRIM 9'h0aa
`define RST_VCO_UPPER_CAL_TRIM 9'h0ff
`endif

//--- pkg/vco_output_config_pkg.sv
// Types of the VCO output configuration bank
package vco_output_config_pkg;
    typedef enum logic [1:0] {
        prio_low_current = 2'h1,
        prio_best_noise = 2'h3
    } prio_mode_t;
    typedef enum logic [1:0] {
        mute_on_div_zero = 2'h0,
        mute_on_cal = 2'h1,
        mute_on_cal_or_unlock = 2'h2,
        mute_always = 2'h3
    } mute_mode_t;
endpackage

//--- sim/cfg_host.sv
// Serial host model issuing indirect configuration writes
`timescale 1ns/10ps
module cfg_host (
    // Clock
    input wire logic clk,
    // Indirect write port
    output logic wr_stb,
    output logic [2:0] wr_subsys_id,
    output logic [3:0] wr_addr,
    output logic [8:0] wr_data
);
    // Idle values that no accepted write uses
    initial begin
        wr_stb = 1'b0;
        wr_subsys_id = 3'h7;
        wr_addr = 4'hf;
        wr_data = 9'h000;
    end
    // trim values come from the caller unchanged
    task put(input logic [2:0] id, input logic [3:0] a, input logic [8:0] d);
        logic [8:0] w;
        w = (a == 4'h3) ? {d[8:7], 1'b0, d[5:1], 1'b1} : d;
        @(posedge clk);
        #1;
        wr_stb = 1'b1;
        wr_subsys_id = id;
        wr_addr = a;
        wr_data = w;
        @(posedge clk);
        #1;
        wr_stb = 1'b0;
        wr_data = ~w; // Stale word must not look valid
    endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the VCO output configuration bank
`timescale 1ns/10ps
module tb_top;
    logic clk, rst_b, busy, lock;
    logic [5:0] div;
    logic stb, bn, pl, nl, it, hr, mute;
    logic [2:0] id;
    logic [3:0] a;
    logic [8:0] d, t4, t5, t6;
    int n_fail = 0;
    int n_compared = 0;
    cfg_host host (.clk(clk), .wr_stb(stb), .wr_subsys_id(id), .wr_addr(a), .wr_data(d));
    vco_output_config_regs DUT (.clk(clk), .rst_b(rst_b), .wr_stb(stb), .wr_subsys_id(id),
        .wr_addr(a), .wr_data(d), .vco_cal_busy(busy), .lock_detect(lock), .out_divide_ratio(div),
        .best_noise_mode(bn), .positive_output_leg(pl), .negative_output_leg(nl),
        .internal_term_en(it), .high_out_res(hr), .output_mute(mute),
        .cal_bias_trim(t4), .coarse_cal_trim(t5), .upper_cal_trim(t6));
    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input string n, input logic [8:0] e, input logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task t_reset;
        chk("decoded", 9'h004, {4'h0, bn, hr, it, nl, pl});
        chk("mute", 9'h000, {8'h0, mute});
        chk("coarse", 9'h0aa, t5);
        chk("upper", 9'h0ff, t6);
        chk("bias", 9'h0c9, t4);
        $display("test reset done");
    endtask
    // Required trim values only; a misrouted write would disturb a neighbour
    task t_trim;
        host.put(3'h0, 4'h4, 9'h0c9);
        host.put(3'h0, 4'h5, 9'h0aa);
        host.put(3'h0, 4'h6, 9'h0ff);
        host.put(3'h1, 4'h4, 9'h000);
        chk("bias", 9'h0c9, t4);
        chk("coarse", 9'h0aa, t5);
        chk("upper", 9'h0ff, t6);
        $display("test trim done");
    endtask
    task t_config;
        host.put(3'h0, 4'h3, 9'h18f);
        chk("decoded", 9'h013, {4'h0, bn, hr, it, nl, pl});
        @(posedge clk);
        #1;
        chk("mute", 9'h001, {8'h0, mute});
        host.put(3'h0, 4'h3, 9'h020);
        chk("decoded", 9'h008, {4'h0, bn, hr, it, nl, pl});
        host.put(3'h1, 4'h3, 9'h18f);
        host.put(3'h0, 4'h7, 9'h18f);
        chk("refused", 9'h008, {4'h0, bn, hr, it, nl, pl});
        $display("test config done");
    endtask
    // Three input sets, expected mute per mode as one nibble each
    task t_mute;
        logic [3:0] e [3];
        e = '{4'h9, 4'he, 4'hc};
        for (int s = 0; s < 3; s++) begin
            for (int m = 0; m < 4; m++) begin
                busy = (s == 1);
                lock = (s != 2);
                div = (s == 0) ? 6'h00 : 6'h05;
                host.put(3'h0, 4'h3, {m[1:0], 7'h01});
                @(posedge clk);
                #1;
                chk("mute mode", {8'h0, e[s][m]}, {8'h0, mute});
            end
        end
        $display("test mute done");
    endtask
    initial begin
        rst_b = 1'b0;
        busy = 1'b0;
        lock = 1'b1;
        div = 6'h01;
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_config();
        t_trim();
        t_mute();
        @(posedge clk);
        #1;
        busy = 1'b0;
        rst_b = 1'b0;
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        final_report();
    end
    task final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
endmodule
